// *** hdl/eppr_pkg.sv ***
// package of constants for the extended parallel port register set
package eppr_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFF_PORT_DATA = 4'h0;
   localparam logic [3:0] OFF_CABLE_STATUS = 4'h1;
   localparam logic [3:0] OFF_CABLE_CONTROL = 4'h2;
   localparam logic [3:0] OFF_ADDR_RLE_FIFO = 4'h3;
   localparam logic [3:0] OFF_COMPAT_FIFO = 4'h4;
   localparam logic [3:0] OFF_EXT_DATA_FIFO = 4'h5;
   localparam logic [3:0] OFF_TEST_FIFO = 4'h6;
   localparam logic [3:0] OFF_CONFIG_A = 4'h7;
   localparam logic [3:0] OFF_CONFIG_B = 4'h8;
   localparam logic [3:0] OFF_EXT_CONTROL = 4'h9;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'hA;
   localparam logic [3:0] OFF_IRQ_MASK = 4'hB;
   // field positions
   localparam int CTL_DIR_BIT = 5;
   localparam int CTL_ACKIE_BIT = 4;
   localparam int ECR_ERRIE_BIT = 4;
   localparam int ECR_DMA_REQUEST_ENABLE_BIT = 3;
   localparam int ECR_SVC_BIT = 2;
   localparam int ECR_FULL_BIT = 1;
   localparam int ECR_EMPTY_BIT = 0;
   localparam int ECR_MODE_LSB = 5;
   localparam int CFGB_COMPRESS_BIT = 7;
   localparam int CFGB_IRQLVL_BIT = 6;
   localparam int CFGB_IRQ_LSB = 3;
   localparam int CFGB_DMA_LSB = 0;
   // interrupt status bit positions
   localparam int IRQ_ACK_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam int IRQ_SVC_BIT = 2;
   // values after reset and fixed patterns
   localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ECR_RESET = 8'h15;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [2:0] MODE_EPP = 3'h4;
   localparam logic [2:0] MODE_TEST = 3'h6;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_W = 8;
endpackage

// *** hdl/eppr_regs.sv ***
// register set, shared fifo and direction logic of the extended parallel port
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - direction output low means outbound write, high means inbound read
// - direction rests low; high only when direction bit set or enhanced read runs
// - in enhanced cycles control bit 5 overrides both the write strobe and the direction
// - all four fifo views share one 16-byte storage fifo
// - every port word is 8 bits wide
// - status and control registers reachable in every mode
// - config b reports the chip-level irq and dma selection
// - config b holds compress flag, irq level flag, irq and dma fields
// - extended control holds mode, error irq enable, dma enable, service, full, empty
// - channel is half-duplex, one direction at a time
// - cable bytes use an interlocked strobe and acknowledge handshake
// - run-length compression is not built here; COMPRESS_SUPPORTED only sets the config b compress flag
module eppr_regs #(
   parameter int DEPTH = eppr_pkg::FIFO_DEPTH,
   parameter int W = eppr_pkg::WORD_W,
   parameter logic COMPRESS_SUPPORTED = 1'b0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [W-1:0] reg_rdata,
   // chip-level configuration
   input wire logic [2:0] cfg_irq_select,
   input wire logic [2:0] cfg_dma_select,
   input wire logic cfg_irq_level,
   // enhanced-mode cycle engine
   input wire logic enh_read_active,
   input wire logic enh_cycle_active,
   input wire logic enh_write_strobe_low,
   input wire logic fifo_pop,
   output logic [W-1:0] fifo_head,
   output logic fifo_head_is_addr,
   output logic fifo_valid,
   input wire logic fifo_push_in,
   input wire logic [W-1:0] fifo_push_data,
   // cable pins, dma request enable and interrupt
   input wire logic busy_in,
   input wire logic ack_in_low,
   input wire logic paper_error_in,
   input wire logic printer_selected_in,
   input wire logic error_in_low,
   input wire logic [W-1:0] pdata_in,
   output logic [W-1:0] pdata_out,
   output logic [3:0] cable_ctl_out,
   output logic write_strobe_low,
   output logic bus_direction_out,
   output logic dma_request_enable,
   output logic irq
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [2:0] ack_s;
      logic [2:0] err_s;
      logic [4:0][2:0] pin_s;
      logic [W-1:0][2:0] pd_s;
      logic ack_prev;
      logic err_prev;
      logic [W-1:0] data;
      logic [W-1:0] ctl;
      logic [2:0] mode;
      logic err_ie_n;
      logic dma_en;
      logic svc;
      logic [7:0] sts;
      logic [7:0] mask;
      logic [DEPTH-1:0][W:0] mem;
      logic [AW-1:0] rp;
      logic [AW-1:0] wp;
      logic [AW:0] cnt;
      logic [W-1:0] rdata;
   } eppr_state_type;

   eppr_state_type s_q;
   eppr_state_type s_d;

   logic full;
   logic empty;
   logic push;
   logic pop;
   logic [W:0] push_word;
   logic ack_f;
   logic err_f;
   logic [4:0] pins_f;
   logic [W-1:0] pd_f;

   // ----------------------------------------------------------------
   // fifo status and synchronised pins
   // ----------------------------------------------------------------
   assign full = (s_q.cnt == (AW+1)'(DEPTH));
   assign empty = (s_q.cnt == '0);
   assign ack_f = (s_q.ack_s[1] == s_q.ack_s[2]) ? s_q.ack_s[2] : s_q.ack_prev;
   assign err_f = (s_q.err_s[1] == s_q.err_s[2]) ? s_q.err_s[2] : s_q.err_prev;
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pins_f[i] = s_q.pin_s[i][2];
      end
      for (int i = 0; i < W; i++) begin
         pd_f[i] = s_q.pd_s[i][2];
      end
   end

   always_comb begin
      push = 1'b0;
      push_word = '0;
      if (reg_wr && !full) begin
         case (reg_addr)
            eppr_pkg::OFF_ADDR_RLE_FIFO: begin
               push = 1'b1;
               push_word = {1'b1, reg_wdata};
            end
            eppr_pkg::OFF_COMPAT_FIFO, eppr_pkg::OFF_EXT_DATA_FIFO,
               eppr_pkg::OFF_TEST_FIFO: begin
               push = 1'b1;
               push_word = {1'b0, reg_wdata};
            end
            default: begin
               push = 1'b0;
            end
         endcase
      end else if (fifo_push_in && !full && !s_q.ctl[eppr_pkg::CTL_DIR_BIT] == 1'b0) begin
         // reverse fill only while the port looks inbound: half-duplex
         push = 1'b1;
         push_word = {1'b0, fifo_push_data};
      end
      pop = 1'b0;
      if (!empty) begin
         if (reg_rd && (reg_addr == eppr_pkg::OFF_EXT_DATA_FIFO
                        || reg_addr == eppr_pkg::OFF_TEST_FIFO)) begin
            pop = 1'b1;
         end else if (fifo_pop) begin
            pop = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack_s = {s_q.ack_s[1:0], ack_in_low};
      s_d.err_s = {s_q.err_s[1:0], error_in_low};
      s_d.pin_s[0] = {s_q.pin_s[0][1:0], busy_in};
      s_d.pin_s[1] = {s_q.pin_s[1][1:0], paper_error_in};
      s_d.pin_s[2] = {s_q.pin_s[2][1:0], printer_selected_in};
      s_d.pin_s[3] = {s_q.pin_s[3][1:0], ack_in_low};
      s_d.pin_s[4] = {s_q.pin_s[4][1:0], error_in_low};
      for (int i = 0; i < W; i++) begin
         s_d.pd_s[i] = {s_q.pd_s[i][1:0], pdata_in[i]};
      end
      s_d.ack_prev = ack_f;
      s_d.err_prev = err_f;
      s_d.rdata = '0;

      // fifo storage
      if (push) begin
         s_d.mem[s_q.wp] = push_word;
         s_d.wp = s_q.wp + AW'(1);
      end
      if (pop) begin
         s_d.rp = s_q.rp + AW'(1);
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);

      // register writes; status and control decode ignore the mode
      if (reg_wr) begin
         case (reg_addr)
            eppr_pkg::OFF_PORT_DATA: begin
               s_d.data = reg_wdata;
            end
            eppr_pkg::OFF_CABLE_CONTROL: begin
               s_d.ctl = {2'b00, reg_wdata[5:0]};
            end
            eppr_pkg::OFF_EXT_CONTROL: begin
               s_d.mode = reg_wdata[7:5];
               s_d.err_ie_n = reg_wdata[eppr_pkg::ECR_ERRIE_BIT];
               s_d.dma_en = reg_wdata[eppr_pkg::ECR_DMA_REQUEST_ENABLE_BIT];
               s_d.svc = reg_wdata[eppr_pkg::ECR_SVC_BIT];
            end
            eppr_pkg::OFF_IRQ_MASK: begin
               s_d.mask = reg_wdata;
            end
            default: begin
               s_d.data = s_d.data;
            end
         endcase
      end

      // sticky events; a read clears but a same-cycle event survives
      if (reg_rd && reg_addr == eppr_pkg::OFF_IRQ_STATUS) begin
         s_d.sts = '0;
      end
      if (s_q.ack_prev && !ack_f && s_q.ctl[eppr_pkg::CTL_ACKIE_BIT]) begin
         s_d.sts[eppr_pkg::IRQ_ACK_BIT] = 1'b1;
      end
      if (s_q.err_prev && !err_f && !s_q.err_ie_n) begin
         s_d.sts[eppr_pkg::IRQ_ERR_BIT] = 1'b1;
      end
      if (s_q.dma_en && full && !s_q.svc) begin
         s_d.svc = 1'b1;
         s_d.sts[eppr_pkg::IRQ_SVC_BIT] = 1'b1;
      end

      // read data stands the cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            eppr_pkg::OFF_PORT_DATA: begin
               s_d.rdata = s_q.ctl[eppr_pkg::CTL_DIR_BIT] ? pd_f : s_q.data;
            end
            eppr_pkg::OFF_CABLE_STATUS: begin
               s_d.rdata = {~pins_f[0], pins_f[3], pins_f[1], pins_f[2],
                            pins_f[4], 3'b000};
            end
            eppr_pkg::OFF_CABLE_CONTROL: begin
               s_d.rdata = s_q.ctl;
            end
            eppr_pkg::OFF_EXT_DATA_FIFO, eppr_pkg::OFF_TEST_FIFO: begin
               s_d.rdata = empty ? '0 : s_q.mem[s_q.rp][W-1:0];
            end
            eppr_pkg::OFF_CONFIG_A: begin
               s_d.rdata = eppr_pkg::CONFIG_A_VALUE;
            end
            eppr_pkg::OFF_CONFIG_B: begin
               s_d.rdata = {COMPRESS_SUPPORTED, cfg_irq_level, cfg_irq_select,
                            cfg_dma_select};
            end
            eppr_pkg::OFF_EXT_CONTROL: begin
               s_d.rdata = {s_q.mode, s_q.err_ie_n, s_q.dma_en, s_q.svc,
                            full, empty};
            end
            eppr_pkg::OFF_IRQ_STATUS: begin
               s_d.rdata = s_q.sts;
            end
            eppr_pkg::OFF_IRQ_MASK: begin
               s_d.rdata = s_q.mask;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end

      if (!resetn) begin
         s_d = '0;
         s_d.ctl = eppr_pkg::CONTROL_RESET;
         s_d.mode = eppr_pkg::MODE_RESET;
         s_d.err_ie_n = 1'b1;
         s_d.svc = 1'b1;
         s_d.mask = eppr_pkg::MASK_RESET;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata = s_q.rdata;
   assign pdata_out = s_q.data;
   assign fifo_head = s_q.mem[s_q.rp][W-1:0];
   assign fifo_head_is_addr = s_q.mem[s_q.rp][W];
   assign fifo_valid = !empty;
   assign cable_ctl_out = s_q.ctl[3:0];
   assign dma_request_enable = s_q.dma_en;
   assign irq = |(s_q.sts & s_q.mask);
   // bit 5 of control or an enhanced read turns the bus inbound
   assign bus_direction_out = s_q.ctl[eppr_pkg::CTL_DIR_BIT] || enh_read_active;
   // control bit 5 overrides the write strobe, forcing it high, as it also forces the direction inbound
   assign write_strobe_low = enh_cycle_active ?
      (enh_write_strobe_low | s_q.ctl[eppr_pkg::CTL_DIR_BIT]) : 1'b1;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   dir_low_rest_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!s_q.ctl[5] && !enh_read_active) |-> !bus_direction_out)
      else $error("direction high without cause");
   dir_high_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      enh_read_active |-> bus_direction_out)
      else $error("direction low during enhanced read");
   dir_ctl_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.ctl[eppr_pkg::CTL_DIR_BIT] |-> bus_direction_out)
      else $error("direction low with control bit set");
   fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.cnt <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
   flags_exclusive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(full && empty))
      else $error("fifo full and empty together");
   full_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (full && !pop) |=> full)
      else $error("full fifo lost a word without pop");
   empty_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (empty && !push) |=> empty)
      else $error("empty fifo gained a word without push");
   addr_tag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == eppr_pkg::OFF_ADDR_RLE_FIFO && empty) |=>
      (fifo_head_is_addr && fifo_valid))
      else $error("address view word not tagged");
   data_tag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == eppr_pkg::OFF_TEST_FIFO && empty) |=>
      (!fifo_head_is_addr && fifo_valid))
      else $error("data view word tagged as address");
   rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside read");
   data_out_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == eppr_pkg::OFF_PORT_DATA) |=> pdata_out == $past(reg_wdata))
      else $error("data register not on cable");
   cfg_a_fixed_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_CONFIG_A) |=> reg_rdata == 8'h10)
      else $error("config a pattern wrong");
   status_low_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_CABLE_STATUS) |=> reg_rdata[2:0] == 3'h0)
      else $error("status low bits not zero");
   ctl_top_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_CABLE_CONTROL) |=> reg_rdata[7:6] == 2'h0)
      else $error("control top bits not zero");
   ctl_top_held_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_q.ctl[7:6] == 2'h0)
      else $error("control top bits stored");
   cfg_b_tracks_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_CONFIG_B) |=>
      reg_rdata[5:0] == {$past(cfg_irq_select), $past(cfg_dma_select)})
      else $error("config b not tracking selection");
   cfg_b_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_CONFIG_B) |=>
      reg_rdata[7:6] == {COMPRESS_SUPPORTED, $past(cfg_irq_level)})
      else $error("config b flags wrong");
   ecr_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_EXT_CONTROL) |=>
      reg_rdata[1:0] == {$past(full), $past(empty)})
      else $error("fifo flags wrong");
   ecr_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_EXT_CONTROL) |=>
      reg_rdata[7:5] == $past(s_q.mode))
      else $error("mode field wrong");
   ecr_enables_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == eppr_pkg::OFF_EXT_CONTROL) |=>
      reg_rdata[4:2] == $past({s_q.err_ie_n, s_q.dma_en, s_q.svc}))
      else $error("extended control enables wrong");
   dma_out_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == eppr_pkg::OFF_EXT_CONTROL) |=>
      dma_request_enable == $past(reg_wdata[eppr_pkg::ECR_DMA_REQUEST_ENABLE_BIT]))
      else $error("dma enable not taken");
   svc_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_q.dma_en && full && !s_q.svc) |=> s_q.svc)
      else $error("service bit not set on full");
   err_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_q.sts[eppr_pkg::IRQ_ERR_BIT] && !(reg_rd && reg_addr == eppr_pkg::OFF_IRQ_STATUS))
      |=> s_q.sts[eppr_pkg::IRQ_ERR_BIT])
      else $error("error event lost without read");
   irq_mask_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_q.mask == '0) |-> !irq)
      else $error("interrupt with all events masked");
   reverse_block_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (fifo_push_in && !reg_wr && !s_q.ctl[eppr_pkg::CTL_DIR_BIT] && !pop) |=>
      s_q.cnt == $past(s_q.cnt))
      else $error("reverse fill while outbound");
   strobe_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !enh_cycle_active |-> write_strobe_low)
      else $error("write strobe active outside cycle");
   strobe_override_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (enh_cycle_active && s_q.ctl[eppr_pkg::CTL_DIR_BIT]) |-> write_strobe_low)
      else $error("control bit did not hold strobe high");
   strobe_pass_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (enh_cycle_active && !s_q.ctl[eppr_pkg::CTL_DIR_BIT]) |->
      write_strobe_low == enh_write_strobe_low)
      else $error("engine strobe not passed through");
endmodule
`default_nettype wire

// *** tb/eppr_periph.sv ***
// peripheral model that stands on the parallel cable
`timescale 1ns/10ps
`default_nettype none
module eppr_periph (
   // clock and bench command
   input wire logic ref_clk,
   input wire logic raise_err,
   // cable
   input wire logic write_strobe_low,
   input wire logic bus_direction_out,
   output logic busy_in,
   output logic ack_in_low,
   output logic paper_error_in,
   output logic printer_selected_in,
   output logic error_in_low,
   output logic [7:0] pdata_in
);
   initial begin
      busy_in = 1'b0;
      ack_in_low = 1'b1;
      paper_error_in = 1'b0;
      printer_selected_in = 1'b1;
      error_in_low = 1'b1;
      pdata_in = 8'h00;
   end
   // busy answers each strobe level, so the host must wait on it
   always @(posedge ref_clk) begin
      busy_in <= ~write_strobe_low;
      error_in_low <= ~raise_err;
      // only drive data while the host reads; otherwise a changing pattern
      pdata_in <= bus_direction_out ? 8'hA5 : ~pdata_in;
   end
endmodule
`default_nettype wire

// *** tb/eppr_regs_tb.sv ***
// self-checking bench for the extended parallel port register set
`timescale 1ns/10ps
`default_nettype none
module eppr_regs_tb;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] irq_sel = 3'h5;
   logic [2:0] dma_sel = 3'h2;
   logic irq_lvl = 1'b1;
   logic enh_rd = 1'b0;
   logic enh_cyc = 1'b0;
   logic enh_wsl = 1'b1;
   logic pop = 1'b0;
   logic raise_err = 1'b0;
   logic [7:0] head, pdata_in, pdata_out, d;
   logic head_addr, fvalid, busy_in, ack_n, perr, sel, err_n, wsl, dir, dma_en, irq;
   logic [3:0] ctl_out;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;
   int i;

   initial forever #10 ref_clk = ~ref_clk;

   eppr_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cfg_irq_select(irq_sel), .cfg_dma_select(dma_sel), .cfg_irq_level(irq_lvl),
      .enh_read_active(enh_rd), .enh_cycle_active(enh_cyc),
      .enh_write_strobe_low(enh_wsl), .fifo_pop(pop), .fifo_head(head),
      .fifo_head_is_addr(head_addr), .fifo_valid(fvalid), .fifo_push_in(1'b0),
      .fifo_push_data(8'h00), .busy_in(busy_in), .ack_in_low(ack_n),
      .paper_error_in(perr), .printer_selected_in(sel), .error_in_low(err_n),
      .pdata_in(pdata_in), .pdata_out(pdata_out), .cable_ctl_out(ctl_out),
      .write_strobe_low(wsl), .bus_direction_out(dir), .dma_request_enable(dma_en),
      .irq(irq));

   eppr_periph u_periph (.ref_clk(ref_clk), .raise_err(raise_err),
      .write_strobe_low(wsl), .bus_direction_out(dir), .busy_in(busy_in),
      .ack_in_low(ack_n), .paper_error_in(perr), .printer_selected_in(sel),
      .error_in_low(err_n), .pdata_in(pdata_in));

   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // the run should need well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      chk({7'h00, dir}, 8'h00);
      rd(eppr_pkg::OFF_CONFIG_A, d); chk(d, 8'h10);
      rd(eppr_pkg::OFF_CABLE_CONTROL, d); chk(d, 8'h00);
      rd(eppr_pkg::OFF_EXT_CONTROL, d); chk(d, 8'h15);
      rd(4'hF, d); chk(d, 8'h00);
      rd(eppr_pkg::OFF_CONFIG_B, d); chk(d, 8'h6A);
      irq_sel <= 3'h3;
      dma_sel <= 3'h1;
      irq_lvl <= 1'b0;
      rd(eppr_pkg::OFF_CONFIG_B, d); chk(d, 8'h19);
      // direction bit, top bits and cable outputs
      wr(eppr_pkg::OFF_CABLE_CONTROL, 8'hFF);
      rd(eppr_pkg::OFF_CABLE_CONTROL, d); chk(d, 8'h3F);
      chk({dir, 3'h0, ctl_out}, 8'h8F);
      settle(4);
      rd(eppr_pkg::OFF_PORT_DATA, d); chk(d, 8'hA5);
      enh_cyc <= 1'b1;
      enh_wsl <= 1'b0;
      settle(1);
      chk({7'h00, wsl}, 8'h01);
      wr(eppr_pkg::OFF_CABLE_CONTROL, 8'h00);
      settle(1);
      chk({dir, 6'h00, wsl}, 8'h00);
      enh_rd <= 1'b1;
      settle(1);
      chk({7'h00, dir}, 8'h01);
      enh_rd <= 1'b0;
      enh_cyc <= 1'b0;
      settle(1);
      chk({7'h00, dir}, 8'h00);
      // test mode, error irq enabled, shared fifo filled past full
      wr(eppr_pkg::OFF_EXT_CONTROL, 8'hC0);
      rd(eppr_pkg::OFF_EXT_CONTROL, d); chk({d[7:5], 3'h0, d[1:0]}, 8'hC1);
      for (i = 0; i < 17; i++) begin
         wr(eppr_pkg::OFF_TEST_FIFO, 8'h30 + 8'(i));
      end
      rd(eppr_pkg::OFF_EXT_CONTROL, d); chk({6'h00, d[1:0]}, 8'h02);
      rd(eppr_pkg::OFF_CABLE_STATUS, d); chk(d & 8'h7F, 8'h58);
      for (i = 0; i < 16; i++) begin
         rd(eppr_pkg::OFF_TEST_FIFO, d); chk(d, 8'h30 + 8'(i));
      end
      rd(eppr_pkg::OFF_TEST_FIFO, d); chk(d, 8'h00);
      rd(eppr_pkg::OFF_EXT_CONTROL, d); chk({6'h00, d[1:0]}, 8'h01);
      // error interrupt: masked first, then unmasked, cleared by read
      raise_err <= 1'b1;
      settle(8);
      chk({7'h00, irq}, 8'h00);
      rd(eppr_pkg::OFF_CABLE_STATUS, d); chk(d, 8'hD0);
      wr(eppr_pkg::OFF_IRQ_MASK, 8'h02);
      settle(1);
      chk({7'h00, irq}, 8'h01);
      rd(eppr_pkg::OFF_IRQ_STATUS, d); chk(d, 8'h02);
      settle(1);
      chk({7'h00, irq}, 8'h00);
      rd(eppr_pkg::OFF_IRQ_STATUS, d); chk(d, 8'h00);
      raise_err <= 1'b0;
      // data register, address view tag and engine pop
      wr(eppr_pkg::OFF_PORT_DATA, 8'h5A);
      rd(eppr_pkg::OFF_PORT_DATA, d); chk(d, 8'h5A);
      chk(pdata_out, 8'h5A);
      wr(eppr_pkg::OFF_ADDR_RLE_FIFO, 8'h12);
      settle(1);
      chk({fvalid, head_addr, 6'h00}, 8'hC0);
      chk(head, 8'h12);
      pop <= 1'b1;
      @(posedge ref_clk);
      pop <= 1'b0;
      settle(1);
      chk({7'h00, fvalid}, 8'h00);
      wr(eppr_pkg::OFF_EXT_CONTROL, 8'hC8);
      settle(1);
      chk({7'h00, dma_en}, 8'h01);
      print_verdict();
   end
endmodule
`default_nettype wire
